// ===== shared/jsa_pkg.sv
/*
 * jsa_pkg: constants, states and carriers for the jog switch axis controller.
 * Assumes a 100 MHz system clock; pin groups arrive unsynchronised.
 */
`default_nettype none

package jsa_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int PASS_MIN_NS    = 50;
	localparam int FLT_PASS_CYC   = PASS_MIN_NS / CLK_PERIOD_NS;
	localparam int LIM_REJECT_NS  = 3000;
	localparam int LIM_REJECT_CYC = LIM_REJECT_NS / CLK_PERIOD_NS + 1;
	localparam int IDX_PASS_NS    = 150;
	localparam int IDX_PASS_CYC   = IDX_PASS_NS / CLK_PERIOD_NS;
	localparam int JOG_REJECT_MS  = 26;
	localparam int JOG_REJECT_CYC = JOG_REJECT_MS * 1000000 / CLK_PERIOD_NS + 1;
	localparam int FLT_CNT_W      = 22;

	// ----------------------------------------------------------------
	// register map (byte offsets) and commands
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_ENV1   = 8'h04;
	localparam logic [7:0] REG_ENV2   = 8'h08;
	localparam logic [7:0] REG_ENV3   = 8'h0C;
	localparam logic [7:0] REG_MOVE   = 8'h10;
	localparam logic [7:0] REG_REMAIN = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_SENSE  = 8'h1C;
	localparam logic [7:0] REG_SPD    = 8'h20;
	localparam logic [7:0] REG_EVENT  = 8'h24;
	localparam logic [7:0] REG_IRQEN  = 8'h28;
	localparam logic [7:0] REG_SPEED  = 8'h2C;
	localparam logic [7:0] MODE_CONT  = 8'h02;
	localparam logic [7:0] MODE_INCR  = 8'h56;
	localparam logic [7:0] CMD_STOP   = 8'h40;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int B_ELM = 3, B_ORGL = 7, B_DRL = 25, B_FLTR = 26, B_DRF = 27;
	localparam int B_EINF = 18, B_EZL = 23, B_EZD = 4;
	localparam int B_SEZ = 10, B_SDRP = 11, B_SDRM = 12;
	localparam int B_SPEL = 12, B_SMEL = 13, B_SORG = 14, B_SORGP = 15;
	localparam int B_EZC = 16, B_EV_P = 17, B_EV_M = 18, B_HS = 16, B_IRQEN = 0;

	// filter channel indices
	localparam int CH_JP = 0, CH_JM = 1, CH_EN = 2, CH_LP = 3, CH_LM = 4;
	localparam int CH_HOME = 5, CH_IDX = 6, CH_EA = 7, CH_EB = 8, CH_LPOL = 9, NCH = 10;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_WAIT  = 4'b0001,
		ST_RUN   = 4'b0010,
		ST_DECEL = 4'b0011
	} jsa_state_t;

	typedef struct packed {
		logic plus_jog_switch;
		logic minus_jog_switch;
		logic jog_port_enable_n;
		logic plus_limit_input;
		logic minus_limit_input;
		logic limit_polarity_pin;
		logic home_sensor_input;
		logic index_pulse_input;
		logic encoder_phase_a;
		logic encoder_phase_b;
	} jsa_pins_t;

	typedef struct packed {
		logic pulse;
		logic dir;
	} jsa_drive_t;

	typedef struct packed {
		logic        limit_stop_method;
		logic        home_polarity;
		logic        jog_polarity;
		logic        limit_home_filter;
		logic        jog_filter;
		logic        index_filter;
		logic        index_polarity;
		logic [3:0]  index_count_preset;
		logic        jog_change_irq_enable;
		logic        high_speed;
		logic [15:0] period;
	} jsa_cfg_t;

endpackage

`default_nettype wire

// ===== hw/jsa_axis.sv
/*
 * jsa_axis: one axis of jog switch motion control with input conditioning.
 * Assumes pins are asynchronous to clock and the register master follows
 * the one-cycle strobe protocol with read data one cycle later.
 */
// The implementer's own choices: strobed register access and the placing of the registers.
// Behaviour
// - continuous mode pulses while switch held
// - release keeps mode; only stop ends it
// - switches edge triggered; held at start ignored
// - opposite switch ignored while in run state
// - high speed decel stop, then reverse
// - continuous limit stop keeps mode active
// - incremental edge loads remaining from move
// - incremental stops at zero remaining
// - incremental edges accepted only while waiting
// - incremental limit stop keeps mode active
// - refuse jog toward active limit
// - home polarity bit selects logic
// - limit/home filter pass or reject
// - home sampled with each command pulse
// - index polarity; count on rising edge
// - index down-counter from preset
// - encoder/index filter selection
// - limit polarity pin selects logic
// - limit stop method immediate or decel
// - home and index status bits
// - plus and minus limit status bits
// - jog only while enable pin low
// - jog polarity bit selects logic
// - jog filter pass or reject
// - jog change sets event flags
`timescale 1ns/1ps
`default_nettype none

module jsa_axis #(
	parameter int          PERIOD_W     = 16,
	parameter logic [7:0]  DECEL_PULSES = 8'h08,
	parameter int unsigned JOG_FLT_CYC  = jsa_pkg::JOG_REJECT_CYC
) (
	input  wire logic               clock,
	input  wire logic               sys_rst,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output var  logic [31:0]        reg_rdata,
	input  wire jsa_pkg::jsa_pins_t pins,
	output var  jsa_pkg::jsa_drive_t drive
);
	import jsa_pkg::*;

	function automatic logic on_level(input logic raw, input logic positive);
		on_level = positive ? raw : ~raw;
	endfunction

	// ----------------------------------------------------------------
	// synchronisers and noise filters
	// ----------------------------------------------------------------
	logic [NCH-1:0]       raw;
	logic [NCH-1:0]       sync1;
	logic [NCH-1:0]       sync2;
	logic [NCH-1:0]       flt;
	logic [NCH-1:0]       next_flt;
	logic [FLT_CNT_W-1:0] flt_cnt [NCH];
	logic [FLT_CNT_W-1:0] next_flt_cnt [NCH];
	logic [FLT_CNT_W-1:0] thr [NCH];
	jsa_cfg_t             cfg;
	jsa_cfg_t             next_cfg;

	always_comb begin
		raw = '0;
		raw[CH_JP]   = pins.plus_jog_switch;
		raw[CH_JM]   = pins.minus_jog_switch;
		raw[CH_EN]   = pins.jog_port_enable_n;
		raw[CH_LP]   = pins.plus_limit_input;
		raw[CH_LM]   = pins.minus_limit_input;
		raw[CH_HOME] = pins.home_sensor_input;
		raw[CH_IDX]  = pins.index_pulse_input;
		raw[CH_EA]   = pins.encoder_phase_a;
		raw[CH_EB]   = pins.encoder_phase_b;
		raw[CH_LPOL] = pins.limit_polarity_pin;
		for (int i = 0; i < NCH; i++) begin
			thr[i] = FLT_CNT_W'(FLT_PASS_CYC);
		end
		if (cfg.jog_filter) begin
			thr[CH_JP] = FLT_CNT_W'(JOG_FLT_CYC);
			thr[CH_JM] = FLT_CNT_W'(JOG_FLT_CYC);
			thr[CH_EN] = FLT_CNT_W'(JOG_FLT_CYC);
		end
		if (cfg.limit_home_filter) begin
			thr[CH_LP]   = FLT_CNT_W'(LIM_REJECT_CYC);
			thr[CH_LM]   = FLT_CNT_W'(LIM_REJECT_CYC);
			thr[CH_HOME] = FLT_CNT_W'(LIM_REJECT_CYC);
		end
		if (cfg.index_filter) begin
			thr[CH_IDX] = FLT_CNT_W'(IDX_PASS_CYC);
			thr[CH_EA]  = FLT_CNT_W'(IDX_PASS_CYC);
			thr[CH_EB]  = FLT_CNT_W'(IDX_PASS_CYC);
		end
		thr[CH_LPOL] = FLT_CNT_W'(1);
		next_flt = flt;
		// a level is accepted only after it has held for thr cycles
		for (int i = 0; i < NCH; i++) begin
			next_flt_cnt[i] = '0;
			if (sync2[i] != flt[i]) begin
				if (flt_cnt[i] + 1'b1 >= thr[i]) begin
					next_flt[i] = sync2[i];
				end else begin
					next_flt_cnt[i] = flt_cnt[i] + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		sync1 <= raw;
		sync2 <= sync1;
		if (sys_rst) begin
			flt <= '0;
			for (int i = 0; i < NCH; i++) begin
				flt_cnt[i] <= '0;
			end
		end else begin
			flt <= next_flt;
			flt_cnt <= next_flt_cnt;
		end
	end

	// ----------------------------------------------------------------
	// input levels after polarity
	// ----------------------------------------------------------------
	logic jog_p_on, jog_m_on, enabled, lim_p_on, lim_m_on, home_on, index_on;

	always_comb begin
		jog_p_on = on_level(flt[CH_JP], cfg.jog_polarity);
		jog_m_on = on_level(flt[CH_JM], cfg.jog_polarity);
		enabled  = ~flt[CH_EN];
		lim_p_on = on_level(flt[CH_LP], ~flt[CH_LPOL]);
		lim_m_on = on_level(flt[CH_LM], ~flt[CH_LPOL]);
		home_on  = on_level(flt[CH_HOME], cfg.home_polarity);
		index_on = on_level(flt[CH_IDX], cfg.index_polarity);
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [31:0] move_amount;
	logic [31:0] next_move_amount;

	always_comb begin
		next_cfg = cfg;
		next_move_amount = move_amount;
		if (reg_wr) begin
			case (reg_addr)
				REG_ENV1: begin
					next_cfg.limit_stop_method = reg_wdata[B_ELM];
					next_cfg.home_polarity     = reg_wdata[B_ORGL];
					next_cfg.jog_polarity      = reg_wdata[B_DRL];
					next_cfg.limit_home_filter = reg_wdata[B_FLTR];
					next_cfg.jog_filter        = reg_wdata[B_DRF];
				end
				REG_ENV2: begin
					next_cfg.index_filter   = reg_wdata[B_EINF];
					next_cfg.index_polarity = reg_wdata[B_EZL];
				end
				REG_ENV3:  next_cfg.index_count_preset = reg_wdata[B_EZD +: 4];
				REG_IRQEN: next_cfg.jog_change_irq_enable = reg_wdata[B_IRQEN];
				REG_SPEED: begin
					next_cfg.period     = reg_wdata[15:0];
					next_cfg.high_speed = reg_wdata[B_HS];
				end
				// software keeps this within the legal move range
				REG_MOVE:  next_move_amount = reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cfg <= '0;
			move_amount <= '0;
		end else begin
			cfg <= next_cfg;
			move_amount <= next_move_amount;
		end
	end

	// ----------------------------------------------------------------
	// edges, event flags and index counter
	// ----------------------------------------------------------------
	logic       prev_p, prev_m, prev_idx, next_prev_p, next_prev_m, next_prev_idx;
	logic [1:0] events, next_events;
	logic [3:0] idx_cnt, next_idx_cnt;
	logic       edge_p, edge_m, idx_rise;

	always_comb begin
		edge_p = jog_p_on & ~prev_p & enabled;
		edge_m = jog_m_on & ~prev_m & enabled;
		idx_rise = index_on & ~prev_idx;
		next_prev_p = jog_p_on;
		next_prev_m = jog_m_on;
		next_prev_idx = index_on;
		next_events = events;
		if (reg_wr && reg_addr == REG_EVENT) begin
			next_events = events & ~{reg_wdata[B_EV_M], reg_wdata[B_EV_P]};
		end
		// set wins over a same-cycle clear
		if (enabled && cfg.jog_change_irq_enable) begin
			next_events = next_events | {jog_m_on ^ prev_m, jog_p_on ^ prev_p};
		end
		next_idx_cnt = idx_cnt;
		// down-count; a rising edge that finds the count at zero reloads the preset
		if (reg_wr && reg_addr == REG_ENV3) begin
			next_idx_cnt = reg_wdata[B_EZD +: 4];
		end else if (idx_rise) begin
			next_idx_cnt = (idx_cnt == 4'h0) ? cfg.index_count_preset : idx_cnt - 4'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// start as if on, so a level seen right after reset is no edge
			prev_p <= 1'b1;
			prev_m <= 1'b1;
			prev_idx <= 1'b1;
			events <= 2'h0;
			idx_cnt <= 4'h0;
		end else begin
			prev_p <= next_prev_p;
			prev_m <= next_prev_m;
			prev_idx <= next_prev_idx;
			events <= next_events;
			idx_cnt <= next_idx_cnt;
		end
	end

	// ----------------------------------------------------------------
	// motion state machine and pulse generator
	// ----------------------------------------------------------------
	jsa_state_t          state, next_state;
	logic                run_dir, next_run_dir;
	logic                incr_mode, next_incr_mode;
	logic                pend_rev, next_pend_rev;
	logic [31:0]         remaining, next_remaining;
	logic [PERIOD_W-1:0] per_cnt, next_per_cnt, per_reload;
	logic [7:0]          decel_left, next_decel_left;
	logic                home_at_pulse, next_home_at_pulse;
	jsa_drive_t          next_drive;
	logic                tick, dir_limit, run_sw_on, cmd_wr, take_p, take_m, emit, last;

	always_comb begin
		cmd_wr = reg_wr && reg_addr == REG_CMD;
		per_reload = (cfg.period[PERIOD_W-1:0] == '0) ? '0 : cfg.period[PERIOD_W-1:0] - 1'b1;
		tick = per_cnt == '0;
		dir_limit = run_dir ? lim_p_on : lim_m_on;
		run_sw_on = (run_dir ? jog_p_on : jog_m_on) & enabled;
		// a jog toward an active limit is refused
		take_p = edge_p & ~lim_p_on;
		take_m = edge_m & ~lim_m_on & ~take_p;
		next_state = state;
		next_run_dir = run_dir;
		next_incr_mode = incr_mode;
		next_pend_rev = pend_rev;
		next_remaining = remaining;
		next_per_cnt = tick ? per_reload : per_cnt - 1'b1;
		next_decel_left = decel_left;
		emit = 1'b0;
		last = 1'b0;
		case (state)
			ST_IDLE: begin
				if (cmd_wr && (reg_wdata[7:0] == MODE_CONT || reg_wdata[7:0] == MODE_INCR)) begin
					next_state = ST_WAIT;
					next_incr_mode = reg_wdata[7:0] == MODE_INCR;
				end
			end
			// edges are taken only while waiting
			ST_WAIT: begin
				next_pend_rev = 1'b0;
				next_per_cnt = '0;
				if (take_p || take_m) begin
					next_run_dir = take_p;
					// load remaining count from the move amount
					if (incr_mode) begin
						next_remaining = move_amount;
						if (move_amount != 32'h0) begin
							next_state = ST_RUN;
						end
					end else begin
						next_state = ST_RUN;
					end
				end
			end
			// no edge is looked at in the run state
			ST_RUN: begin
				// limit stop stays inside the mode
				if (dir_limit) begin
					if (cfg.limit_stop_method) begin
						next_state = ST_DECEL;
						next_decel_left = DECEL_PULSES;
					end else begin
						next_state = ST_WAIT;
					end
				end else if (!incr_mode && !run_sw_on) begin
					next_state = cfg.high_speed ? ST_DECEL : ST_WAIT;
					next_decel_left = DECEL_PULSES;
				end else if (tick) begin
					emit = 1'b1;
				end
			end
			ST_DECEL: begin
				// reversal request is held until the stop is done
				if (!incr_mode && (run_dir ? edge_m : edge_p)) begin
					next_pend_rev = 1'b1;
				end
				if (tick) begin
					emit = 1'b1;
					next_decel_left = decel_left - 8'h01;
					last = decel_left <= 8'h01;
				end
				if (last) begin
					next_state = ST_WAIT;
					if (next_pend_rev && (run_dir ? (jog_m_on & enabled & ~lim_m_on)
						: (jog_p_on & enabled & ~lim_p_on))) begin
						next_state = ST_RUN;
						next_run_dir = ~run_dir;
						next_per_cnt = '0;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
		if (emit && incr_mode) begin
			next_remaining = remaining - 32'h1;
			// zero ends the move, mode stays
			if (remaining == 32'h1) begin
				next_state = ST_WAIT;
			end
		end
		// the stop command alone ends the mode
		if (cmd_wr && reg_wdata[7:0] == CMD_STOP) begin
			next_state = ST_IDLE;
			next_pend_rev = 1'b0;
		end
		next_drive.pulse = emit;
		next_drive.dir = emit ? run_dir : drive.dir;
		// home is sampled with every pulse
		next_home_at_pulse = emit ? home_on : home_at_pulse;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			run_dir <= 1'b0;
			incr_mode <= 1'b0;
			pend_rev <= 1'b0;
			remaining <= '0;
			per_cnt <= '0;
			decel_left <= '0;
			home_at_pulse <= 1'b0;
			drive <= '0;
		end else begin
			state <= next_state;
			run_dir <= next_run_dir;
			incr_mode <= next_incr_mode;
			pend_rev <= next_pend_rev;
			remaining <= next_remaining;
			per_cnt <= next_per_cnt;
			decel_left <= next_decel_left;
			home_at_pulse <= next_home_at_pulse;
			drive <= next_drive;
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				REG_ENV1: begin
					next_rdata[B_ELM]  = cfg.limit_stop_method;
					next_rdata[B_ORGL] = cfg.home_polarity;
					next_rdata[B_DRL]  = cfg.jog_polarity;
					next_rdata[B_FLTR] = cfg.limit_home_filter;
					next_rdata[B_DRF]  = cfg.jog_filter;
				end
				REG_ENV2: begin
					next_rdata[B_EINF] = cfg.index_filter;
					next_rdata[B_EZL]  = cfg.index_polarity;
				end
				REG_ENV3:   next_rdata[B_EZD +: 4] = cfg.index_count_preset;
				REG_MOVE:   next_rdata = move_amount;
				REG_REMAIN: next_rdata = remaining;
				REG_STATUS: begin
					next_rdata[3:0]    = state;
					next_rdata[B_SEZ]  = index_on;
					next_rdata[B_SDRP] = jog_p_on;
					next_rdata[B_SDRM] = jog_m_on;
				end
				REG_SENSE: begin
					next_rdata[B_SPEL]  = lim_p_on;
					next_rdata[B_SMEL]  = lim_m_on;
					next_rdata[B_SORG]  = home_on;
					next_rdata[B_SORGP] = home_at_pulse;
				end
				REG_SPD: begin
					next_rdata[B_EZC +: 4] = idx_cnt;
					next_rdata[1:0] = {flt[CH_EB], flt[CH_EA]};
				end
				REG_EVENT: begin
					next_rdata[B_EV_P] = events[0];
					next_rdata[B_EV_M] = events[1];
				end
				REG_IRQEN: next_rdata[B_IRQEN] = cfg.jog_change_irq_enable;
				REG_SPEED: next_rdata = {15'h0000, cfg.high_speed, cfg.period};
				default:   next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	a_pulse_from_motion: assert property (drive.pulse |-> $past(state) inside {ST_RUN, ST_DECEL})
		else $error("pulse outside motion");
	a_stop_ends_mode: assert property (cmd_wr && reg_wdata[7:0] == CMD_STOP |=> state == ST_IDLE)
		else $error("stop did not end mode");
	a_release_keeps_mode: assert property (state == ST_RUN && !incr_mode && !run_sw_on && !dir_limit
		&& !cfg.high_speed && !cmd_wr |=> state == ST_WAIT)
		else $error("release left mode");
	a_run_dir_stable: assert property (state == ST_RUN && $past(state) == ST_RUN |-> $stable(run_dir))
		else $error("direction changed during motion");
	a_limit_stop: assert property (state == ST_RUN && dir_limit && !cfg.limit_stop_method && !cmd_wr
		|=> state == ST_WAIT ##1 !drive.pulse)
		else $error("limit did not stop motion");
	a_limit_decel: assert property (state == ST_RUN && dir_limit && cfg.limit_stop_method && !cmd_wr
		|=> state == ST_DECEL)
		else $error("limit did not decelerate");
	a_incr_load: assert property (state == ST_WAIT && incr_mode && (take_p || take_m) && !cmd_wr
		|=> remaining == $past(move_amount))
		else $error("remaining not loaded");
	a_incr_nonzero: assert property (state == ST_RUN && incr_mode |-> remaining != 32'h0)
		else $error("running with zero remaining");
	a_limit_refuse: assert property (state == ST_WAIT && edge_p && lim_p_on && !edge_m && !cmd_wr
		|=> state == ST_WAIT)
		else $error("jog into limit accepted");
	a_event_set: assert property (enabled && cfg.jog_change_irq_enable && (jog_p_on != prev_p)
		|=> events[0])
		else $error("plus jog event missed");
	a_index_count: assert property (idx_rise && idx_cnt != 4'h0 && !(reg_wr && reg_addr == REG_ENV3)
		|=> idx_cnt == $past(idx_cnt) - 4'h1)
		else $error("index count wrong");

	c_cont_run: cover property (state == ST_RUN && !incr_mode ##1 drive.pulse);
	c_incr_done: cover property (state == ST_RUN && incr_mode ##1 state == ST_WAIT);
	c_decel_reverse: cover property (state == ST_DECEL && pend_rev ##1 state == ST_RUN);
	c_limit_stop: cover property (state == ST_RUN && dir_limit);

endmodule // jsa_axis

`default_nettype wire

// ===== tb/jsa_far_side.sv
/* jsa_far_side: jog switches, sensors and motor drive beside one axis.
   Assumes the bench sets switch and limit levels as on/off. */
`timescale 1ns/1ps
`default_nettype none

module jsa_far_side (
	input  wire logic                clock,
	input  wire logic                clr,
	input  wire jsa_pkg::jsa_drive_t drive,
	input  wire logic [1:0]          sw,
	input  wire logic [1:0]          lim,
	input  wire logic                en_n,
	input  wire logic [2:0]          aux,
	output var  jsa_pkg::jsa_pins_t  pins,
	output var  int                  pulses,
	output var  logic                last_dir
);
	import jsa_pkg::*;

	// switches pull to ground when on, so the reset polarity reads them
	// aux: home on, index on, limit polarity pin; sensors read low when on
	// home held for long stretches, far longer than one pulse
	always_comb begin
		pins = '0;
		pins.plus_jog_switch   = ~sw[0];
		pins.minus_jog_switch  = ~sw[1];
		pins.jog_port_enable_n = en_n;
		pins.plus_limit_input  = lim[0];
		pins.minus_limit_input = lim[1];
		pins.home_sensor_input  = ~aux[0];
		pins.index_pulse_input  = ~aux[1];
		pins.limit_polarity_pin = aux[2];
	end

	// the drive only counts pulses and keeps the last direction
	always_ff @(posedge clock) begin
		if (clr)
			pulses <= 0;
		else if (drive.pulse === 1'b1)
			pulses <= pulses + 1;
		if (drive.pulse === 1'b1)
			last_dir <= drive.dir;
	end
endmodule // jsa_far_side

`default_nettype wire

// ===== tb/tb_jog_switch_axis_control.sv
/* tb_jog_switch_axis_control: register table, then jog scenarios.
   Assumes the far-side model and a jog filter cut to 50 cycles. */
`timescale 1ns/1ps
`default_nettype none

module tb_jog_switch_axis_control;
	import jsa_pkg::*;

	typedef struct packed {
		logic        we;
		logic [7:0]  wa;
		logic [31:0] d;
		logic [7:0]  ra;
		logic [31:0] e;
	} jsa_row_t;

	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        clr = 1'b0;
	logic        en_n = 1'b0;
	logic [7:0]  reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic [31:0] reg_rdata;
	logic [1:0]  sw = '0;
	logic [1:0]  lim = '0;
	logic [2:0]  aux = '0;
	jsa_pins_t   pins;
	jsa_drive_t  drive;
	int          pulses;
	logic        last_dir;
	int          mismatches = 0;
	int          checks_done = 0;

	jsa_row_t rows [8] = '{
		'{1'b0, REG_CMD, 32'h0, REG_STATUS, 32'h0},
		'{1'b1, REG_MOVE, 32'h3, REG_MOVE, 32'h3},
		'{1'b1, REG_REMAIN, 32'h5, REG_REMAIN, 32'h0},
		'{1'b1, 8'h30, 32'h1, 8'h30, 32'h0},
		'{1'b1, REG_ENV3, 32'h50, REG_SPD, 32'h5_0000},
		'{1'b1, REG_IRQEN, 32'h1, REG_IRQEN, 32'h1},
		'{1'b1, REG_SPEED, 32'h1, REG_SPEED, 32'h1},
		'{1'b0, REG_CMD, 32'h0, REG_SENSE, 32'h0}
	};

	always #5 clock = ~clock;

	jsa_axis #(.JOG_FLT_CYC(50)) dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pins(pins), .drive(drive));
	jsa_far_side far (.clock(clock), .clr(clr), .drive(drive), .sw(sw), .lim(lim),
		.en_n(en_n), .aux(aux), .pins(pins), .pulses(pulses), .last_dir(last_dir));

	// ----------------------------------------------------------------
	// bus cycles and comparisons
	// ----------------------------------------------------------------
	task automatic print_verdict();
		if (mismatches == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk($sformatf("reg %h", a), e, reg_rdata);
	endtask

	// filter needs 2 sync plus 5 stable cycles before a level shows
	task automatic run(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic zap();
		@(posedge clock) clr <= 1'b1;
		@(posedge clock) clr <= 1'b0;
	endtask

	initial begin
		#50000;
		mismatches++;
		print_verdict();
	end

	initial begin
		run(8);
		sys_rst <= 1'b0;
		run(12);
		foreach (rows[i]) begin
			if (rows[i].we)
				wr(rows[i].wa, rows[i].d);
			rchk(rows[i].ra, rows[i].e);
		end
		@(posedge clock) aux <= 3'b111;
		run(12);
		rchk(REG_STATUS, 32'h400);
		rchk(REG_SENSE, 32'h7000);
		@(posedge clock) aux <= 3'b000;
		run(12);
		@(posedge clock) aux <= 3'b010;
		run(12);
		@(posedge clock) aux <= 3'b000;
		run(12);
		rchk(REG_SPD, 32'h3_0000);
		wr(REG_CMD, MODE_INCR);
		rchk(REG_STATUS, 32'h1);
		zap();
		@(posedge clock) sw <= 2'b01;
		run(30);
		chk("incr pulses", 32'd3, pulses);
		chk("incr dir", 32'h1, {31'b0, last_dir});
		rchk(REG_REMAIN, 32'h0);
		rchk(REG_STATUS, 32'h801);
		wr(REG_CMD, CMD_STOP);
		@(posedge clock) sw <= 2'b10;
		run(12);
		wr(REG_CMD, MODE_CONT);
		zap();
		run(30);
		chk("held at start", 32'd0, pulses);
		@(posedge clock) sw <= 2'b00;
		run(12);
		@(posedge clock) sw <= 2'b01;
		run(20);
		rchk(REG_STATUS, 32'h802);
		rchk(REG_EVENT, 32'h6_0000);
		@(posedge clock) sw <= 2'b11;
		run(20);
		rchk(REG_STATUS, 32'h1802);
		chk("cont dir", 32'h1, {31'b0, last_dir});
		@(posedge clock) sw <= 2'b00;
		run(12);
		rchk(REG_STATUS, 32'h1);
		@(posedge clock) lim <= 2'b01;
		run(12);
		rchk(REG_SENSE, 32'h1000);
		zap();
		@(posedge clock) sw <= 2'b01;
		run(20);
		chk("toward limit", 32'd0, pulses);
		@(posedge clock) sw <= 2'b00;
		run(12);
		@(posedge clock) sw <= 2'b10;
		run(20);
		chk("off limit", 32'h1, {31'b0, pulses > 0});
		chk("off dir", 32'h0, {31'b0, last_dir});
		@(posedge clock) lim <= 2'b11;
		run(12);
		zap();
		run(10);
		chk("limit stop", 32'd0, pulses);
		rchk(REG_STATUS, 32'h1001);
		@(posedge clock) sw <= 2'b00;
		lim  <= 2'b00;
		en_n <= 1'b1;
		run(12);
		wr(REG_EVENT, 32'h6_0000);
		zap();
		@(posedge clock) sw <= 2'b01;
		run(20);
		chk("disabled", 32'd0, pulses);
		rchk(REG_EVENT, 32'h0);
		@(posedge clock) sw <= 2'b00;
		en_n <= 1'b0;
		wr(REG_SPEED, 32'h1_0001);
		wr(REG_ENV1, 32'h88);
		run(12);
		@(posedge clock) sw <= 2'b01;
		run(20);
		// minus turns on while the plus release is still decelerating
		@(posedge clock) sw <= 2'b00;
		run(2);
		sw <= 2'b10;
		run(30);
		chk("reverse dir", 32'h0, {31'b0, last_dir});
		rchk(REG_STATUS, 32'h1002);
		@(posedge clock) lim <= 2'b10;
		run(8);
		rchk(REG_STATUS, 32'h1003);
		run(20);
		rchk(REG_STATUS, 32'h1001);
		rchk(REG_SENSE, 32'hE000);
		print_verdict();
	end
endmodule // tb_jog_switch_axis_control

`default_nettype wire
